// *** design/gtc_pkg.sv ***
// Shared constants and types for the gated 16-bit timer/counter.
// Assumes a single 100 MHz system clock; the register map is reached over APB.

package gtc_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int GTC_ADDR_W = 8;
   localparam logic [7:0] GTC_OFS_COUNT_LOW = 8'h00;
   localparam logic [7:0] GTC_OFS_COUNT_HIGH = 8'h04;
   localparam logic [7:0] GTC_OFS_CTRL = 8'h08;
   localparam logic [7:0] GTC_OFS_GATE = 8'h0C;
   localparam logic [7:0] GTC_OFS_STATUS = 8'h10;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int GTC_GATE_EN_BIT = 7;
   localparam int GTC_GATE_LVL_BIT = 0;
   localparam int GTC_STAT_ARMED_BIT = 0;
   localparam int GTC_STAT_GATE_BIT = 1;
   localparam int GTC_STAT_EXT_BIT = 2;
   localparam logic [7:0] GTC_CTRL_RST = 8'h00;
   localparam logic [7:0] GTC_CTRL_WMASK = 8'hF5;
   localparam logic [15:0] GTC_COUNT_RST = 16'h0000;
   localparam logic GTC_GATE_EN_RST = 1'b0;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   // One instruction cycle is four system clocks; the phase counter wraps here.
   localparam logic [1:0] GTC_PHASE_LAST = 2'h3;

   // ----------------------------------------------------------------
   // Pin inputs
   // ----------------------------------------------------------------
   localparam int GTC_NPINS = 3;
   localparam int GTC_PIN_EXT = 0;
   localparam int GTC_PIN_GATE = 1;
   localparam int GTC_PIN_LF = 2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      GTC_SRC_INSTR = 2'h0,
      GTC_SRC_SYS = 2'h1,
      GTC_SRC_EXT = 2'h2,
      GTC_SRC_LF = 2'h3
   } gtc_src_t;

   typedef struct packed {
      gtc_src_t src;
      logic [1:0] prescale;
      logic rsv3;
      logic async_ext;
      logic rsv1;
      logic run;
   } gtc_ctrl_t;

   typedef struct packed {
      logic [GTC_NPINS-1:0] level;
      logic [GTC_NPINS-1:0] rise;
      logic [GTC_NPINS-1:0] fall;
   } gtc_pins_t;

endpackage

// *** design/gtc_pin_sync.sv ***
// Three-stage synchroniser with agreement filter for the timer's pin inputs.
// Assumes the reset it receives is already released synchronously to clk_i.
`timescale 1ns/10ps
`default_nettype none

module gtc_pin_sync (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [gtc_pkg::GTC_NPINS-1:0] pin_i,
   output gtc_pkg::gtc_pins_t pins_o
);

   logic [gtc_pkg::GTC_NPINS-1:0] s1_reg;
   logic [gtc_pkg::GTC_NPINS-1:0] s2_reg;
   logic [gtc_pkg::GTC_NPINS-1:0] s3_reg;
   logic [gtc_pkg::GTC_NPINS-1:0] level_reg;
   logic [gtc_pkg::GTC_NPINS-1:0] level_next;
   gtc_pkg::gtc_pins_t pins_reg;
   gtc_pkg::gtc_pins_t pins_next;

   // A level is accepted only once two later stages agree, so a pin that is
   // still settling never produces a half-seen edge.
   always_comb begin
      level_next = level_reg;
      for (int i = 0; i < gtc_pkg::GTC_NPINS; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            level_next[i] = s3_reg[i];
         end
      end
      pins_next.level = level_next;
      pins_next.rise = level_next & ~level_reg;
      pins_next.fall = ~level_next & level_reg;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         level_reg <= '0;
         pins_reg <= '0;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level_reg <= level_next;
         pins_reg <= pins_next;
      end
   end

   assign pins_o = pins_reg;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   AST_SYNC_AGREE: assert property (
      (level_reg != $past(level_reg)) |-> ($past(s2_reg) == $past(s3_reg)))
      else $error("Pin level changed before the synchroniser stages agreed.");

endmodule
`default_nettype wire

// *** design/gtc_timer.sv ***
// Gated 16-bit timer/counter with an APB register slave.
// Assumes a 100 MHz clk_i; pins arrive asynchronously and are synchronised here.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module gtc_timer (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [gtc_pkg::GTC_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic external_clock_pin_i,
   input wire logic gate_pin_i,
   input wire logic low_freq_internal_osc_i,
   output logic [15:0] count_o
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_reg;
   logic rst_n;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   gtc_pkg::gtc_pins_t pins;

   gtc_pin_sync u_pin_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .pin_i({low_freq_internal_osc_i, gate_pin_i, external_clock_pin_i}),
      .pins_o(pins)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic addr_hit(input logic [gtc_pkg::GTC_ADDR_W-1:0] a);
      addr_hit = (a == gtc_pkg::GTC_OFS_COUNT_LOW) || (a == gtc_pkg::GTC_OFS_COUNT_HIGH) ||
                 (a == gtc_pkg::GTC_OFS_CTRL) || (a == gtc_pkg::GTC_OFS_GATE) ||
                 (a == gtc_pkg::GTC_OFS_STATUS);
   endfunction

   function automatic logic [2:0] psc_max(input logic [1:0] sel);
      psc_max = 3'((4'h1 << sel) - 4'h1);
   endfunction

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   gtc_pkg::gtc_ctrl_t ctrl_reg;
   gtc_pkg::gtc_ctrl_t ctrl_next;
   logic gate_en_reg;
   logic gate_en_next;
   logic [15:0] count_reg;
   logic armed_reg;
   logic commit;
   logic wr_low;
   logic wr_high;
   logic wr_count;

   // A transfer completes at the edge where pready is high; every access
   // therefore takes exactly one wait state.
   assign commit = psel_i & penable_i & pready_reg;
   assign wr_low = commit & pwrite_i & (paddr_i == gtc_pkg::GTC_OFS_COUNT_LOW);
   assign wr_high = commit & pwrite_i & (paddr_i == gtc_pkg::GTC_OFS_COUNT_HIGH);
   assign wr_count = wr_low | wr_high;

   always_comb begin
      pready_next = psel_i & penable_i & ~pready_reg;
      pslverr_next = 1'b0;
      prdata_next = 32'h0000_0000;
      ctrl_next = ctrl_reg;
      gate_en_next = gate_en_reg;
      if (pready_next) begin
         pslverr_next = ~addr_hit(paddr_i);
         if (!pwrite_i) begin
            case (paddr_i)
               gtc_pkg::GTC_OFS_COUNT_LOW: prdata_next[7:0] = count_reg[7:0];
               gtc_pkg::GTC_OFS_COUNT_HIGH: prdata_next[7:0] = count_reg[15:8];
               gtc_pkg::GTC_OFS_CTRL: prdata_next[7:0] = ctrl_reg;
               gtc_pkg::GTC_OFS_GATE: begin
                  prdata_next[gtc_pkg::GTC_GATE_EN_BIT] = gate_en_reg;
                  prdata_next[gtc_pkg::GTC_GATE_LVL_BIT] = pins.level[gtc_pkg::GTC_PIN_GATE];
               end
               gtc_pkg::GTC_OFS_STATUS: begin
                  prdata_next[gtc_pkg::GTC_STAT_ARMED_BIT] = armed_reg;
                  prdata_next[gtc_pkg::GTC_STAT_GATE_BIT] = pins.level[gtc_pkg::GTC_PIN_GATE];
                  prdata_next[gtc_pkg::GTC_STAT_EXT_BIT] = pins.level[gtc_pkg::GTC_PIN_EXT];
               end
               default: prdata_next = 32'h0000_0000;
            endcase
         end
      end
      if (commit && pwrite_i && (paddr_i == gtc_pkg::GTC_OFS_CTRL)) begin
         ctrl_next = gtc_pkg::gtc_ctrl_t'(pwdata_i[7:0] & gtc_pkg::GTC_CTRL_WMASK);
      end
      if (commit && pwrite_i && (paddr_i == gtc_pkg::GTC_OFS_GATE)) begin
         gate_en_next = pwdata_i[gtc_pkg::GTC_GATE_EN_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         ctrl_reg <= gtc_pkg::GTC_CTRL_RST;
         gate_en_reg <= gtc_pkg::GTC_GATE_EN_RST;
      end else begin
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
         ctrl_reg <= ctrl_next;
         gate_en_reg <= gate_en_next;
      end
   end

   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign prdata_o = prdata_reg;

   // ----------------------------------------------------------------
   // Counting core
   // ----------------------------------------------------------------
   logic [1:0] phase_reg;
   logic [1:0] phase_next;
   logic [2:0] pre_reg;
   logic [2:0] pre_next;
   logic pend_reg;
   logic pend_next;
   logic armed_next;
   logic [15:0] count_next;
   logic instr_edge;
   logic cnt_en;
   logic ext_ok;
   logic src_tick;
   logic step;

   always_comb begin
      phase_next = phase_reg + 2'h1;
      instr_edge = (phase_reg == gtc_pkg::GTC_PHASE_LAST);
      cnt_en = ctrl_reg.run & (~gate_en_reg | pins.level[gtc_pkg::GTC_PIN_GATE]);
      ext_ok = armed_reg & pins.rise[gtc_pkg::GTC_PIN_EXT];
      // With async_ext clear, synchronised external edges wait for the instruction-cycle boundary.
      pend_next = cnt_en & ~wr_count & (pend_reg | ext_ok) & ~instr_edge;
      case (ctrl_reg.src)
         gtc_pkg::GTC_SRC_INSTR: src_tick = instr_edge;
         gtc_pkg::GTC_SRC_SYS: src_tick = 1'b1;
         gtc_pkg::GTC_SRC_EXT: begin
            if (ctrl_reg.async_ext) begin
               src_tick = ext_ok;
            end else begin
               src_tick = instr_edge & (pend_reg | ext_ok);
            end
         end
         gtc_pkg::GTC_SRC_LF: src_tick = pins.rise[gtc_pkg::GTC_PIN_LF];
         default: src_tick = 1'b0;
      endcase
      src_tick = src_tick & cnt_en;
      // A prescaler left above a newly written smaller ratio steps at once
      // rather than wrapping through all eight counts first.
      step = src_tick & (pre_reg >= psc_max(ctrl_reg.prescale));
      if (wr_count || !cnt_en) begin
         pre_next = 3'h0;
      end else if (src_tick) begin
         pre_next = step ? 3'h0 : pre_reg + 3'h1;
      end else begin
         pre_next = pre_reg;
      end
      count_next = count_reg + {15'h0000, step};
      if (wr_low) begin
         count_next[7:0] = pwdata_i[7:0];
      end
      if (wr_high) begin
         count_next[15:8] = pwdata_i[7:0];
      end
      // A falling edge in the same cycle as a count write still arms the
      // counter, so the edge is never lost.
      if (!ctrl_reg.run) begin
         armed_next = 1'b0;
      end else if (pins.fall[gtc_pkg::GTC_PIN_EXT]) begin
         armed_next = 1'b1;
      end else if (wr_count) begin
         armed_next = 1'b0;
      end else begin
         armed_next = armed_reg;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= 2'h0;
         pre_reg <= 3'h0;
         pend_reg <= 1'b0;
         armed_reg <= 1'b0;
         count_reg <= gtc_pkg::GTC_COUNT_RST;
      end else begin
         phase_reg <= phase_next;
         pre_reg <= pre_next;
         pend_reg <= pend_next;
         armed_reg <= armed_next;
         count_reg <= count_next;
      end
   end

   assign count_o = count_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n);

   AST_WRITE_LOW: assert property (
      wr_low |=> count_reg[7:0] == $past(pwdata_i[7:0]))
      else $error("Low byte write did not replace the count.");

   AST_WRITE_HIGH: assert property (
      wr_high |=> count_reg[15:8] == $past(pwdata_i[7:0]))
      else $error("High byte write did not replace the count.");

   AST_OFF_HOLD: assert property (
      (!ctrl_reg.run && !wr_count) |=> $stable(count_reg))
      else $error("Count moved while the run bit was clear.");

   AST_GATE_HOLD: assert property (
      (gate_en_reg && !pins.level[gtc_pkg::GTC_PIN_GATE] && !wr_count) |=> $stable(count_reg))
      else $error("Count moved while the gate was inactive.");

   AST_SYS_STEP: assert property (
      (ctrl_reg.src == gtc_pkg::GTC_SRC_SYS && ctrl_reg.prescale == 2'h0 && cnt_en &&
       !wr_count) |=> count_reg == 16'($past(count_reg) + 16'h0001))
      else $error("System clock source did not advance every clock.");

   AST_INSTR_PHASE: assert property (
      (ctrl_reg.src == gtc_pkg::GTC_SRC_INSTR && !wr_count && !instr_edge) |=> $stable(count_reg))
      else $error("Instruction clock source advanced off the cycle boundary.");

   AST_UNARMED_HOLD: assert property (
      (ctrl_reg.src == gtc_pkg::GTC_SRC_EXT && !armed_reg && !pend_reg && !wr_count)
      |=> $stable(count_reg))
      else $error("External count advanced before a falling edge was seen.");

   AST_ARM_CLEAR: assert property (
      (wr_count && !pins.fall[gtc_pkg::GTC_PIN_EXT]) |=> !armed_reg)
      else $error("Count write did not disarm the external counter.");

   AST_WRAP: assert property (
      (step && count_reg == 16'hFFFF && !wr_count) |=> count_reg == 16'h0000)
      else $error("Count did not wrap to zero.");

   AST_PRESCALE: assert property (
      (ctrl_reg.src == gtc_pkg::GTC_SRC_SYS && ctrl_reg.prescale == 2'h1 && cnt_en &&
       !wr_count && pre_reg == 3'h0) ##1
      (ctrl_reg.src == gtc_pkg::GTC_SRC_SYS && ctrl_reg.prescale == 2'h1 && cnt_en && !wr_count)
      |=> count_reg == 16'($past(count_reg, 2) + 16'h0001))
      else $error("Prescaler 1:2 did not halve the step rate.");

   AST_PREADY_PULSE: assert property (
      pready_reg |=> !pready_reg)
      else $error("pready stayed high for more than one cycle.");

   COV_WRAP: cover property (step && count_reg == 16'hFFFF);
   COV_EXT_COUNT: cover property (ctrl_reg.src == gtc_pkg::GTC_SRC_EXT && step);
   COV_GATE_HELD: cover property (gate_en_reg && ctrl_reg.run &&
                                  !pins.level[gtc_pkg::GTC_PIN_GATE]);
   COV_SLVERR: cover property (pslverr_reg && pready_reg);

endmodule
`default_nettype wire

// *** tb/gtc_pin_src.sv ***
// Model of the pins that feed the timer: external count clock, gate and low-frequency source.
// Assumes the bench calls its tasks from just after a rising edge of clk_i.
`timescale 1ns/10ps
`default_nettype none

module gtc_pin_src (
   input wire logic clk_i,
   output logic ext_o,
   output logic gate_o,
   output logic lf_o
);
   initial begin
      ext_o = 1'b0;
      gate_o = 1'b0;
      lf_o = 1'b0;
   end

   // ----------------------------------------------------------------
   // Pin activity
   // ----------------------------------------------------------------
   // Pulses are slow against the synchroniser; the line rests low between bursts.
   task automatic pulse(input int which, input int n);
      for (int i = 0; i < n; i++) begin
         if (which == 0) ext_o <= 1'b1;
         else lf_o <= 1'b1;
         repeat (8) @(posedge clk_i);
         if (which == 0) ext_o <= 1'b0;
         else lf_o <= 1'b0;
         repeat (8) @(posedge clk_i);
      end
   endtask

   // The gate level is moved with no regard to the instruction phase.
   task automatic set_gate(input logic v);
      gate_o <= v;
      repeat (10) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// *** tb/test_gated_16bit_timer_counter.sv ***
// Self-checking bench for the gated 16-bit timer/counter, driven over APB.
// Assumes the design package is compiled first and a 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module test_gated_16bit_timer_counter;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, ext, gate, lf;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] count, d;
   logic e;
   int bad_count = 0;
   int checks_done = 0;

   gtc_timer i_dut (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .external_clock_pin_i(ext),
      .gate_pin_i(gate), .low_freq_internal_osc_i(lf), .count_o(count));
   gtc_pin_src i_src (.clk_i(clk), .ext_o(ext), .gate_o(gate), .lf_o(lf));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Bus and checking tasks
   // ----------------------------------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk(r, exp);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      xfer(1'b1, a, wd);
   endtask

   // Counts the steps seen over a span of clock edges while the timer runs.
   task automatic span(input int cyc);
      logic [15:0] c0;
      c0 = count;
      repeat (cyc) @(posedge clk);
      d = count - c0;
   endtask

   function automatic logic [31:0] mk(input gtc_pkg::gtc_src_t s, input logic [1:0] p,
      input logic a);
      return {24'h000000, s, p, 1'b0, a, 1'b0, 1'b1};
   endfunction

   task automatic end_of_test;
      $display("mismatches %0d, comparisons %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_of_test;
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      rd(gtc_pkg::GTC_OFS_CTRL, 32'h0000_0000);
      rd(gtc_pkg::GTC_OFS_COUNT_LOW, 32'h0000_0000);
      rd(gtc_pkg::GTC_OFS_STATUS, 32'h0000_0000);
      rd(8'h14, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0001);
      wr(gtc_pkg::GTC_OFS_COUNT_LOW, 32'h0000_0034);
      wr(gtc_pkg::GTC_OFS_COUNT_HIGH, 32'h0000_0012);
      chk({16'h0000, count}, 32'h0000_1234);
      rd(gtc_pkg::GTC_OFS_COUNT_HIGH, 32'h0000_0012);
      wr(gtc_pkg::GTC_OFS_CTRL, 32'h0000_00FF);
      rd(gtc_pkg::GTC_OFS_CTRL, 32'h0000_00F5);
      wr(gtc_pkg::GTC_OFS_CTRL, mk(gtc_pkg::GTC_SRC_INSTR, 2'h0, 1'b0));
      span(40);
      chk({16'h0000, d}, 32'h0000_000A);
      for (int p = 0; p < 4; p++) begin
         wr(gtc_pkg::GTC_OFS_CTRL, mk(gtc_pkg::GTC_SRC_SYS, p[1:0], 1'b0));
         span(40);
         chk({16'h0000, d}, 32'(40 >> p));
      end
      wr(gtc_pkg::GTC_OFS_CTRL, 32'h0000_0000);
      span(40);
      chk({16'h0000, d}, 32'h0000_0000);
      // Gate enabled with the pin low must freeze the count, then release it.
      wr(gtc_pkg::GTC_OFS_GATE, 32'h0000_0080);
      rd(gtc_pkg::GTC_OFS_GATE, 32'h0000_0080);
      wr(gtc_pkg::GTC_OFS_CTRL, mk(gtc_pkg::GTC_SRC_SYS, 2'h0, 1'b0));
      span(40);
      chk({16'h0000, d}, 32'h0000_0000);
      i_src.set_gate(1'b1);
      span(40);
      chk({16'h0000, d}, 32'h0000_0028);
      wr(gtc_pkg::GTC_OFS_GATE, 32'h0000_0000);
      i_src.set_gate(1'b0);
      span(40);
      chk({16'h0000, d}, 32'h0000_0028);
      wr(gtc_pkg::GTC_OFS_CTRL, 32'h0000_0000);
      wr(gtc_pkg::GTC_OFS_COUNT_LOW, 32'h0000_00FF);
      wr(gtc_pkg::GTC_OFS_COUNT_HIGH, 32'h0000_00FF);
      wr(gtc_pkg::GTC_OFS_CTRL, mk(gtc_pkg::GTC_SRC_SYS, 2'h0, 1'b0));
      repeat (20) @(posedge clk);
      chk({16'h0000, count}, 32'h0000_0013);
      // The first rise after enable or a count write is ignored until a fall is seen.
      for (int a = 0; a < 2; a++) begin
         wr(gtc_pkg::GTC_OFS_CTRL, 32'h0000_0000);
         wr(gtc_pkg::GTC_OFS_COUNT_LOW, 32'h0000_0000);
         wr(gtc_pkg::GTC_OFS_COUNT_HIGH, 32'h0000_0000);
         wr(gtc_pkg::GTC_OFS_CTRL, mk(gtc_pkg::GTC_SRC_EXT, 2'h0, a[0]));
         i_src.pulse(0, 3);
         repeat (10) @(posedge clk);
         chk({16'h0000, count}, 32'h0000_0002);
         wr(gtc_pkg::GTC_OFS_COUNT_LOW, 32'h0000_0010);
         i_src.pulse(0, 2);
         repeat (10) @(posedge clk);
         chk({16'h0000, count}, 32'h0000_0011);
         rd(gtc_pkg::GTC_OFS_STATUS, 32'h0000_0001);
      end
      wr(gtc_pkg::GTC_OFS_CTRL, 32'h0000_0000);
      wr(gtc_pkg::GTC_OFS_COUNT_LOW, 32'h0000_0000);
      wr(gtc_pkg::GTC_OFS_CTRL, mk(gtc_pkg::GTC_SRC_LF, 2'h0, 1'b0));
      i_src.pulse(1, 4);
      repeat (10) @(posedge clk);
      chk({16'h0000, count}, 32'h0000_0004);
      end_of_test;
   end
endmodule
`default_nettype wire
